// ===== logic/adc_compute_pkg.sv
// Constants and types shared by the computation back end of the converter.
// What this block does
// - At each conversion start the previous result takes the filter result if select is 1, else the raw result.
// - The shift select field sits in control bits 6 to 4, and all eight codes, 000 to 111, give shifts of 0 to 7.
// - In low-pass filter mode the filter time constant is two to the shift value with unity gain.
// - In accumulate, average and burst average modes the accumulator is right-shifted by the shift value.
// - Every division by the shift value truncates by dropping the shifted-out bits, without rounding.
// - Writing 1 to the clear command bit clears accumulator, overflow flag and sample counter, then the bit self-clears.
// - The clear command bit reads 0 whenever no clearing is in progress.
// - The mode field in control bits 2 to 0 selects basic, accumulate, average, burst average or low-pass filter.
// - The computation overflow flag is set only by genuine overflow, never by the filter sign bit alone.
// - Basic mode does no accumulation, filtering or averaging, while conversions still run normally.
// - In accumulate mode each sample adds to the accumulator, bumps the counter until it saturates at 255 and updates the shifted filter result.
package adc_compute_pkg;
    localparam int RES_W = 10;
    localparam int ACC_W = 18;
    localparam int FLT_W = 16;
    localparam int CNT_W = 8;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h1;
    localparam logic [3:0] OFF_RES_LO = 4'h2;
    localparam logic [3:0] OFF_RES_HI = 4'h3;
    localparam logic [3:0] OFF_FLT_LO = 4'h4;
    localparam logic [3:0] OFF_FLT_HI = 4'h5;
    localparam logic [3:0] OFF_PREV_LO = 4'h6;
    localparam logic [3:0] OFF_PREV_HI = 4'h7;
    localparam logic [3:0] OFF_ACC_0 = 4'h8;
    localparam logic [3:0] OFF_ACC_1 = 4'h9;
    localparam logic [3:0] OFF_ACC_2 = 4'ha;
    localparam logic [3:0] OFF_COUNT = 4'hb;
    localparam int PSIS_BIT = 7;
    localparam int SHIFT_MSB = 6;
    localparam int SHIFT_LSB = 4;
    localparam int CLR_BIT = 3;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int GO_BIT = 0;
    localparam int RC_BIT = 1;
    localparam int AOV_BIT = 2;
    localparam int COV_BIT = 3;
    typedef enum logic [2:0] {
        mode_basic = 3'b000,
        mode_accum = 3'b001,
        mode_average = 3'b010,
        mode_burst = 3'b011,
        mode_lowpass = 3'b100
    } compute_mode_e;
    typedef enum logic {
        conv_idle = 1'b0,
        conv_busy = 1'b1
    } conv_state_e;
endpackage

// ===== logic/pin_sync.sv
// Two-stage synchroniser for signals from the converter core.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage1_next;
    logic [W-1:0] q_next;

    always_comb begin
        stage1_next = d;
        q_next = stage1_reg;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1_reg <= '0;
            q <= '0;
        end else begin
            stage1_reg <= stage1_next;
            q <= q_next;
        end
    end
endmodule // pin_sync

// ===== logic/compute_datapath.sv
// Accumulator, sample counter and filter arithmetic.
`timescale 1ns/1ps
module compute_datapath #(
    parameter int RES_W = adc_compute_pkg::RES_W,
    parameter int ACC_W = adc_compute_pkg::ACC_W,
    parameter int FLT_W = adc_compute_pkg::FLT_W,
    parameter int CNT_W = adc_compute_pkg::CNT_W
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic [RES_W-1:0] sample,
    input wire logic [2:0] mode,
    input wire logic [2:0] shift,
    input wire logic clear,
    output logic [ACC_W-1:0] accumulator,
    output logic [CNT_W-1:0] sample_counter,
    output logic accum_overflow_flag,
    output logic [FLT_W-1:0] filter_result,
    output logic overflow_event
);
    logic [ACC_W-1:0] acc_base;
    logic [CNT_W-1:0] cnt_base;
    logic [ACC_W:0] sum;
    logic [ACC_W-1:0] acc_next;
    logic [ACC_W-1:0] shifted;
    logic [CNT_W-1:0] cnt_next;
    logic aov_next;
    logic [FLT_W-1:0] flt_next;
    logic ovf_next;
    logic is_accum;
    logic is_lowpass;

    always_comb begin
        is_accum = (mode == adc_compute_pkg::mode_accum) || (mode == adc_compute_pkg::mode_average)
            || (mode == adc_compute_pkg::mode_burst);
        is_lowpass = (mode == adc_compute_pkg::mode_lowpass);
        acc_base = clear ? '0 : accumulator;
        cnt_base = clear ? '0 : sample_counter;
        aov_next = clear ? 1'b0 : accum_overflow_flag;
        if (is_lowpass) begin
            sum = {1'b0, acc_base - (acc_base >> shift)} + (ACC_W + 1)'(sample);
        end else begin
            sum = {1'b0, acc_base} + (ACC_W + 1)'(sample);
        end
        acc_next = acc_base;
        cnt_next = cnt_base;
        flt_next = filter_result;
        ovf_next = 1'b0;
        shifted = sum[ACC_W-1:0] >> shift;
        if (sample_valid && (is_accum || is_lowpass)) begin
            acc_next = sum[ACC_W-1:0];
            aov_next = aov_next | sum[ACC_W];
            if (cnt_base != '1) begin
                cnt_next = cnt_base + 1'b1;
            end
            flt_next = shifted[FLT_W-1:0];
            ovf_next = sum[ACC_W] || (|shifted[ACC_W-1:FLT_W]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            accumulator <= '0;
            sample_counter <= '0;
            accum_overflow_flag <= 1'b0;
            filter_result <= '0;
            overflow_event <= 1'b0;
        end else begin
            accumulator <= acc_next;
            sample_counter <= cnt_next;
            accum_overflow_flag <= aov_next;
            filter_result <= flt_next;
            overflow_event <= ovf_next;
        end
    end
endmodule // compute_datapath

// ===== logic/adc_computation_control.sv
// Register file, conversion control and previous-sample capture of the computation back end.
`timescale 1ns/1ps
module adc_computation_control #(
    parameter int RES_W = adc_compute_pkg::RES_W,
    parameter int ACC_W = adc_compute_pkg::ACC_W,
    parameter int FLT_W = adc_compute_pkg::FLT_W,
    parameter int CNT_W = adc_compute_pkg::CNT_W
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic conversion_start,
    output logic converter_rc_oscillator,
    input wire logic core_done_toggle,
    input wire logic [RES_W-1:0] core_result
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    adc_compute_pkg::conv_state_e state_reg;
    adc_compute_pkg::conv_state_e state_next;
    logic rc_next;
    logic cov_reg;
    logic cov_next;
    logic start_next;
    logic seen_reg;
    logic seen_next;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] result_next;
    logic [FLT_W-1:0] prev_reg;
    logic [FLT_W-1:0] prev_next;
    logic [7:0] rdata_next;
    logic [RES_W:0] synced;
    logic done_pulse;
    logic sample_valid;
    logic ctrl_wr;
    logic status_wr;
    logic go_req;
    logic prev_sample_source_sel;
    logic [2:0] accum_shift_sel;
    logic accum_clear_cmd;
    logic [2:0] compute_mode_sel;
    logic [ACC_W-1:0] accumulator;
    logic [CNT_W-1:0] sample_counter;
    logic accum_overflow_flag;
    logic [FLT_W-1:0] filter_result;
    logic overflow_event;
    logic [7:0] status_view;

    ////////////////////////////////////////////////////////////////////////////////
    // Core completion toggle and result cross in through two flip-flops.
    pin_sync #(
        .W(RES_W + 1)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .d({core_done_toggle, core_result}),
        .q(synced)
    );

    compute_datapath #(
        .RES_W(RES_W),
        .ACC_W(ACC_W),
        .FLT_W(FLT_W),
        .CNT_W(CNT_W)
    ) u_datapath (
        .clock(clock),
        .reset(reset),
        .sample_valid(sample_valid),
        .sample(synced[RES_W-1:0]),
        .mode(compute_mode_sel),
        .shift(accum_shift_sel),
        .clear(accum_clear_cmd),
        .accumulator(accumulator),
        .sample_counter(sample_counter),
        .accum_overflow_flag(accum_overflow_flag),
        .filter_result(filter_result),
        .overflow_event(overflow_event)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        prev_sample_source_sel = ctrl_reg[adc_compute_pkg::PSIS_BIT];
        accum_shift_sel = ctrl_reg[adc_compute_pkg::SHIFT_MSB:adc_compute_pkg::SHIFT_LSB];
        accum_clear_cmd = ctrl_reg[adc_compute_pkg::CLR_BIT];
        compute_mode_sel = ctrl_reg[adc_compute_pkg::MODE_MSB:adc_compute_pkg::MODE_LSB];
        ctrl_wr = wr && (addr == adc_compute_pkg::OFF_CTRL);
        status_wr = wr && (addr == adc_compute_pkg::OFF_STATUS);
        go_req = status_wr && wdata[adc_compute_pkg::GO_BIT] && (state_reg == adc_compute_pkg::conv_idle);
        done_pulse = synced[RES_W] ^ seen_reg;
        sample_valid = done_pulse && (state_reg == adc_compute_pkg::conv_busy);
        status_view = 8'h00;
        status_view[adc_compute_pkg::GO_BIT] = (state_reg == adc_compute_pkg::conv_busy);
        status_view[adc_compute_pkg::RC_BIT] = converter_rc_oscillator;
        status_view[adc_compute_pkg::AOV_BIT] = accum_overflow_flag;
        status_view[adc_compute_pkg::COV_BIT] = cov_reg;
    end

    // Control register, with the clear command dropping after one cycle of action.
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next[adc_compute_pkg::CLR_BIT] = 1'b0;
        if (ctrl_wr) begin
            ctrl_next = wdata;
        end
    end

    // Conversion sequencing, result capture and previous-sample transfer.
    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        seen_next = synced[RES_W];
        result_next = result_reg;
        prev_next = prev_reg;
        rc_next = converter_rc_oscillator;
        if (status_wr) begin
            rc_next = wdata[adc_compute_pkg::RC_BIT];
        end
        case (state_reg)
            adc_compute_pkg::conv_idle: begin
                if (go_req) begin
                    state_next = adc_compute_pkg::conv_busy;
                    start_next = 1'b1;
                    if (prev_sample_source_sel) begin
                        prev_next = filter_result;
                    end else begin
                        prev_next = FLT_W'(result_reg);
                    end
                end
            end
            adc_compute_pkg::conv_busy: begin
                if (done_pulse) begin
                    state_next = adc_compute_pkg::conv_idle;
                    result_next = synced[RES_W-1:0];
                end
            end
            default: begin
                state_next = adc_compute_pkg::conv_idle;
            end
        endcase
        cov_next = cov_reg;
        if (status_wr && wdata[adc_compute_pkg::COV_BIT]) begin
            cov_next = 1'b0;
        end
        if (overflow_event) begin
            cov_next = 1'b1;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_comb begin
        rdata_next = 8'h00;
        if (rd) begin
            case (addr)
                adc_compute_pkg::OFF_CTRL: rdata_next = ctrl_reg;
                adc_compute_pkg::OFF_STATUS: rdata_next = status_view;
                adc_compute_pkg::OFF_RES_LO: rdata_next = 8'(result_reg);
                adc_compute_pkg::OFF_RES_HI: rdata_next = 8'(result_reg >> 8);
                adc_compute_pkg::OFF_FLT_LO: rdata_next = filter_result[7:0];
                adc_compute_pkg::OFF_FLT_HI: rdata_next = filter_result[15:8];
                adc_compute_pkg::OFF_PREV_LO: rdata_next = prev_reg[7:0];
                adc_compute_pkg::OFF_PREV_HI: rdata_next = prev_reg[15:8];
                adc_compute_pkg::OFF_ACC_0: rdata_next = accumulator[7:0];
                adc_compute_pkg::OFF_ACC_1: rdata_next = accumulator[15:8];
                adc_compute_pkg::OFF_ACC_2: rdata_next = 8'(accumulator >> 16);
                adc_compute_pkg::OFF_COUNT: rdata_next = 8'(sample_counter);
                default: rdata_next = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_reg <= adc_compute_pkg::CTRL_RESET;
            state_reg <= adc_compute_pkg::conv_idle;
            conversion_start <= 1'b0;
            converter_rc_oscillator <= 1'b0;
            cov_reg <= 1'b0;
            seen_reg <= 1'b0;
            result_reg <= '0;
            prev_reg <= '0;
            rdata <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            state_reg <= state_next;
            conversion_start <= start_next;
            converter_rc_oscillator <= rc_next;
            cov_reg <= cov_next;
            seen_reg <= seen_next;
            result_reg <= result_next;
            prev_reg <= prev_next;
            rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_reset_control_zero: assert property ($past(reset) |-> ctrl_reg == 8'h00)
        else $error("control register not zero after reset");
    a_shift_field_store: assert property (ctrl_wr |=> accum_shift_sel == $past(wdata[6:4]))
        else $error("shift field not stored");
    a_clear_self_ends: assert property (accum_clear_cmd |=> !accum_clear_cmd || $past(ctrl_wr))
        else $error("clear command did not self-clear");
    a_clear_reads_zero: assert property (rd && addr == adc_compute_pkg::OFF_CTRL && !accum_clear_cmd
        |=> !rdata[adc_compute_pkg::CLR_BIT])
        else $error("clear bit read 1 while idle");
    a_clear_empties_acc: assert property (accum_clear_cmd && !sample_valid
        |=> accumulator == '0 && sample_counter == '0 && !accum_overflow_flag)
        else $error("clear left accumulator state");
    a_prev_from_filter: assert property (go_req && prev_sample_source_sel
        |=> prev_reg == $past(filter_result))
        else $error("previous result not taken from filter");
    a_prev_from_result: assert property (go_req && !prev_sample_source_sel
        |=> prev_reg == FLT_W'($past(result_reg)))
        else $error("previous result not taken from raw result");
    a_basic_no_accum: assert property (compute_mode_sel == 3'b000 && !accum_clear_cmd
        |=> $stable(accumulator) && $stable(sample_counter))
        else $error("basic mode changed accumulator");
    a_accum_counts: assert property (sample_valid && compute_mode_sel == 3'b001
        && !accum_clear_cmd && sample_counter != '1
        |=> sample_counter == $past(sample_counter) + 1'b1)
        else $error("sample counter not incremented");
    a_accum_shifted: assert property (sample_valid && compute_mode_sel == 3'b001
        |=> filter_result == FLT_W'(accumulator >> $past(accum_shift_sel)))
        else $error("filter result not truncated shift of accumulator");
    a_ovf_genuine: assert property ($rose(cov_reg) |-> $past(overflow_event))
        else $error("overflow flag set without overflow");
    a_start_pulse: assert property (conversion_start |=> !conversion_start)
        else $error("start pulse longer than one cycle");

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on conversion sequencing, register reads and the remaining modes.
    a_go_starts: assert property (go_req
        |=> conversion_start && state_reg == adc_compute_pkg::conv_busy)
        else $error("go request did not start a conversion");
    a_busy_no_restart: assert property (state_reg == adc_compute_pkg::conv_busy && status_wr
        |=> !conversion_start)
        else $error("conversion restarted while busy");
    a_go_reads_busy: assert property (rd && addr == adc_compute_pkg::OFF_STATUS
        && state_reg == adc_compute_pkg::conv_busy |=> rdata[adc_compute_pkg::GO_BIT])
        else $error("go bit not read as set while busy");
    a_result_capture: assert property (sample_valid
        |=> result_reg == $past(synced[RES_W-1:0]))
        else $error("conversion result not captured");
    a_idle_done_ignored: assert property (done_pulse && state_reg == adc_compute_pkg::conv_idle
        && !accum_clear_cmd |=> $stable(accumulator) && $stable(sample_counter))
        else $error("completion while idle changed accumulator");
    a_lowpass_counts: assert property (sample_valid
        && compute_mode_sel == adc_compute_pkg::mode_lowpass
        && !accum_clear_cmd && sample_counter != '1
        |=> sample_counter == $past(sample_counter) + 1'b1)
        else $error("low-pass sample not counted");
    a_lowpass_shifted: assert property (sample_valid
        && compute_mode_sel == adc_compute_pkg::mode_lowpass
        |=> filter_result == FLT_W'(accumulator >> $past(accum_shift_sel)))
        else $error("low-pass output not shifted accumulator");
    a_average_shifted: assert property (sample_valid
        && (compute_mode_sel == adc_compute_pkg::mode_average
        || compute_mode_sel == adc_compute_pkg::mode_burst)
        |=> filter_result == FLT_W'(accumulator >> $past(accum_shift_sel)))
        else $error("average output not shifted accumulator");
    a_reserved_mode_still: assert property (compute_mode_sel > adc_compute_pkg::mode_lowpass
        && !accum_clear_cmd |=> $stable(accumulator) && $stable(filter_result))
        else $error("reserved mode changed accumulator");
    a_basic_filter_still: assert property (compute_mode_sel == adc_compute_pkg::mode_basic
        |=> $stable(filter_result))
        else $error("basic mode changed filter result");
    a_cov_write_clear: assert property (status_wr && wdata[adc_compute_pkg::COV_BIT]
        && !overflow_event |=> !cov_reg)
        else $error("computation overflow not cleared by write");
    a_cov_set_wins: assert property (overflow_event |=> cov_reg)
        else $error("computation overflow not set by overflow");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside read");
    a_ctrl_write_store: assert property (ctrl_wr |=> ctrl_reg == $past(wdata))
        else $error("control write not stored");
    a_rc_follows_write: assert property (status_wr
        |=> converter_rc_oscillator == $past(wdata[adc_compute_pkg::RC_BIT]))
        else $error("clock select not stored");

    c_clear_seen: cover property (accum_clear_cmd ##1 !accum_clear_cmd);
    c_lowpass_sample: cover property (sample_valid && compute_mode_sel == 3'b100);
    c_prev_filter: cover property (go_req && prev_sample_source_sel);
    c_overflow: cover property ($rose(cov_reg));
    c_conversion_done: cover property (sample_valid ##1 state_reg == adc_compute_pkg::conv_idle);
endmodule // adc_computation_control

// ===== tb/adc_computation_control_tb.sv
// Self-checking testbench for the computation back end of the converter.
`timescale 1ns/1ps
module adc_computation_control_tb;
    typedef struct {
        logic [2:0] mode;
        logic [2:0] shift;
        logic [9:0] s;
        logic [17:0] acc;
        logic [15:0] flt;
    } row_s;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic conversion_start;
    logic converter_rc_oscillator;
    logic core_done_toggle = 1'b0;
    logic [adc_compute_pkg::RES_W-1:0] core_result = 10'h000;
    logic rc_sel = 1'b0;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] st;
    logic [7:0] b;
    logic [15:0] v;
    row_s rows [6] = '{
        '{3'h1, 3'h0, 10'h3ff, 18'h003ff, 16'h03ff},
        '{3'h1, 3'h5, 10'h3ff, 18'h003ff, 16'h001f},
        '{3'h2, 3'h3, 10'h2a7, 18'h002a7, 16'h0054},
        '{3'h3, 3'h1, 10'h001, 18'h00001, 16'h0000},
        '{3'h0, 3'h4, 10'h155, 18'h00000, 16'h0000},
        '{3'h4, 3'h2, 10'h0ff, 18'h000ff, 16'h003f}
    };

    adc_computation_control adc_computation_control_inst (
        .clock(clock),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .conversion_start(conversion_start),
        .converter_rc_oscillator(converter_rc_oscillator),
        .core_done_toggle(core_done_toggle),
        .core_result(core_result)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            err_count = err_count + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares = compares + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        logic [7:0] lo;
        logic [7:0] hi;
        rd_reg(a, lo);
        rd_reg(a + 4'h1, hi);
        d = {hi, lo};
    endtask

    task automatic conv(input logic [9:0] s);
        int n;
        wr_reg(adc_compute_pkg::OFF_STATUS, {6'h00, rc_sel, 1'b1});
        #1 chk(conversion_start, 1, "start pulse");
        @(posedge clock);
        #1 chk(conversion_start, 0, "start pulse width");
        rd_reg(adc_compute_pkg::OFF_STATUS, st);
        chk(st[adc_compute_pkg::GO_BIT], 1, "go after idle cycle");
        chk(converter_rc_oscillator, rc_sel, "rc select");
        @(posedge clock);
        core_result <= s;
        @(posedge clock);
        core_done_toggle <= ~core_done_toggle;
        n = 0;
        do begin
            rd_reg(adc_compute_pkg::OFF_STATUS, st);
            n = n + 1;
        end while (st[adc_compute_pkg::GO_BIT] === 1'b1 && n < 20);
        chk(st[adc_compute_pkg::GO_BIT], 0, "go cleared");
        repeat (2) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        #1 chk(rdata, 0, "idle read data");
        rd_reg(adc_compute_pkg::OFF_CTRL, b);
        chk(b, adc_compute_pkg::CTRL_RESET, "control reset");
        rd_reg(adc_compute_pkg::OFF_STATUS, b);
        chk(b, 0, "status reset");
        foreach (rows[i]) begin
            wr_reg(adc_compute_pkg::OFF_CTRL, {1'b0, rows[i].shift, 1'b1, rows[i].mode});
            repeat (3) @(posedge clock);
            rd_reg(adc_compute_pkg::OFF_CTRL, b);
            chk(b, {1'b0, rows[i].shift, 1'b0, rows[i].mode}, "control fields");
            rd_reg(adc_compute_pkg::OFF_COUNT, b);
            chk(b, 0, "count cleared");
            rd16(adc_compute_pkg::OFF_ACC_0, v);
            chk(v, 0, "accumulator cleared");
            rd_reg(adc_compute_pkg::OFF_STATUS, b);
            chk(b[adc_compute_pkg::AOV_BIT], 0, "overflow flag cleared");
            conv(rows[i].s);
            rd16(adc_compute_pkg::OFF_ACC_0, v);
            rd_reg(adc_compute_pkg::OFF_ACC_2, b);
            chk({b[1:0], v}, rows[i].acc, "accumulator");
            if (rows[i].mode != 3'h0) begin
                rd_reg(adc_compute_pkg::OFF_COUNT, b);
                chk(b, 1, "sample count");
                rd16(adc_compute_pkg::OFF_FLT_LO, v);
                chk(v, rows[i].flt, "filter result");
            end
        end
        wr_reg(adc_compute_pkg::OFF_CTRL, 8'h81);
        conv(10'h100);
        rd16(adc_compute_pkg::OFF_PREV_LO, v);
        chk(v, 16'h003f, "previous from filter");
        rd16(adc_compute_pkg::OFF_FLT_LO, v);
        chk(v, 16'h01ff, "running sum");
        wr_reg(adc_compute_pkg::OFF_CTRL, 8'h01);
        conv(10'h001);
        rd16(adc_compute_pkg::OFF_PREV_LO, v);
        chk(v, 16'h0100, "previous from raw");
        rd_reg(adc_compute_pkg::OFF_COUNT, b);
        chk(b, 3, "count after three");
        wr_reg(adc_compute_pkg::OFF_RES_LO, 8'haa);
        rd_reg(adc_compute_pkg::OFF_RES_LO, b);
        chk(b, 8'h01, "read-only result");
        rd_reg(4'hc, b);
        chk(b, 0, "unmapped read");
        wr_reg(adc_compute_pkg::OFF_CTRL, 8'h09);
        rc_sel = 1'b1;
        for (int i = 1; i <= 65; i++) begin
            conv(10'h3ff);
            rd_reg(adc_compute_pkg::OFF_STATUS, st);
            chk(st[adc_compute_pkg::COV_BIT], (i == 65), "computation overflow");
            if (i == 33) begin
                rd_reg(adc_compute_pkg::OFF_FLT_HI, b);
                chk(b[7], 1, "filter sign bit");
            end
        end
        chk(st[adc_compute_pkg::AOV_BIT], 0, "no accumulator overflow");
        wr_reg(adc_compute_pkg::OFF_STATUS, 8'h0a);
        rd_reg(adc_compute_pkg::OFF_STATUS, st);
        chk(st[adc_compute_pkg::COV_BIT], 0, "overflow write clear");
        rd_reg(adc_compute_pkg::OFF_CTRL, b);
        chk(b, 8'h01, "clear bit self clears");
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd_reg(adc_compute_pkg::OFF_CTRL, b);
        chk(b, 8'h00, "control after second reset");
        #1 chk(converter_rc_oscillator, 0, "rc select after reset");
        end_sim();
    end
endmodule // adc_computation_control_tb
